// ### hdl/safety_pkg.sv
package safety_pkg;

	localparam int unsigned CLK_HZ = 50_000_000;

	// APB byte addresses
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_SOS_DLY = 8'h04;
	localparam logic [7:0] ADDR_SS2_DLY = 8'h08;
	localparam logic [7:0] ADDR_SLS_DLY = 8'h0C;
	localparam logic [7:0] ADDR_SS1_DLY = 8'h10;
	localparam logic [7:0] ADDR_TOL     = 8'h14;
	localparam logic [7:0] ADDR_STILL   = 8'h18;
	localparam logic [7:0] ADDR_ACCEL   = 8'h1C;
	localparam logic [7:0] ADDR_RAMP    = 8'h20;
	localparam logic [7:0] ADDR_LIM0    = 8'h24;
	localparam logic [7:0] ADDR_LIM1    = 8'h28;
	localparam logic [7:0] ADDR_LIM2    = 8'h2C;
	localparam logic [7:0] ADDR_LIM3    = 8'h30;
	localparam logic [7:0] ADDR_MARGIN  = 8'h34;
	localparam logic [7:0] ADDR_STATUS  = 8'h38;
	localparam logic [7:0] ADDR_REFPOS  = 8'h3C;

	// Control register fields
	localparam int unsigned CTRL_SOS_SEL   = 0;
	localparam int unsigned CTRL_SS2_SEL   = 1;
	localparam int unsigned CTRL_SS2_EXT   = 2;
	localparam int unsigned CTRL_SLS_SEL   = 3;
	localparam int unsigned CTRL_LVL_LO    = 4;
	localparam int unsigned CTRL_MON_SEL   = 6;
	localparam int unsigned CTRL_SLS_SBR   = 7;
	localparam int unsigned CTRL_SLS_FIXED = 8;
	localparam int unsigned CTRL_ACK       = 9;
	localparam int unsigned CTRL_W         = 10;

	// Reset values of the configuration registers; delays in cycles
	localparam logic [31:0] DLY_RST    = 32'h0000_C350;
	localparam logic [31:0] TOL_RST    = 32'h0000_0010;
	localparam logic [31:0] STILL_RST  = 32'h0000_0004;
	localparam logic [31:0] ACCEL_RST  = 32'h0000_0020;
	localparam logic [31:0] RAMP_RST   = 32'h0000_0001;
	localparam logic [31:0] LIM_RST    = 32'h0000_0100;
	localparam logic [31:0] MARGIN_RST = 32'h0000_0008;

	typedef enum logic [2:0] {
		ST_RUN,
		ST_SOS_WAIT,
		ST_SOS_ACT,
		ST_SS2_BRAKE,
		ST_SS1_BRAKE,
		ST_TORQUE_OFF
	} stop_e;

	typedef struct packed {
		logic torque_off;
		logic fast_stop;
		logic speed_ctrl;
		logic sos_active;
		logic sos_selected;
		logic sls_active;
		logic fault;
	} drive_cmd_s;

	typedef struct packed {
		logic [31:0] pos;
		logic [31:0] vel;
	} feedback_s;

endpackage

// ### hdl/delay_timer.sv
`timescale 1ns/1ps
module delay_timer #(
	parameter int unsigned W = 32
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         start,
	input  wire logic         clear,
	input  wire logic [W-1:0] load,
	output logic              running,
	output logic              done
);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic         run;
		logic         done;
	} st_s;

	st_s s_q;
	st_s s_d;

	initial begin
		if (W < 2) $error("delay_timer: W too small");
	end

	always_comb begin
		s_d      = s_q;
		s_d.done = 1'b0;
		if (clear) begin
			s_d.run = 1'b0;
			s_d.cnt = '0;
		end else if (start) begin
			s_d.run = 1'b1;
			s_d.cnt = (load == '0) ? W'(1) : load;
		end else if (s_q.run) begin
			if (s_q.cnt <= W'(1)) begin
				s_d.run  = 1'b0;
				s_d.done = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt - W'(1);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign running = s_q.run;
	assign done    = s_q.done;

endmodule // delay_timer

// ### hdl/speed_monitor.sv
`timescale 1ns/1ps
module speed_monitor #(
	parameter int unsigned W = 32
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         enable,
	input  wire logic         use_ramp,
	input  wire logic [W-1:0] vel,
	input  wire logic [W-1:0] accel_tol,
	input  wire logic [W-1:0] ramp_step,
	output logic              violation
);

	typedef struct packed {
		logic [W-1:0] peak;
		logic         armed;
		logic         viol;
	} st_s;

	st_s          s_q;
	st_s          s_d;
	logic [W-1:0] mag;

	always_comb begin
		mag = vel[W-1] ? W'(-vel) : vel;
		s_d = s_q;
		s_d.viol = 1'b0;
		if (!enable) begin
			s_d.armed = 1'b0;
		end else if (!s_q.armed) begin
			s_d.armed = 1'b1;
			s_d.peak  = mag;
		end else if (use_ramp) begin
			// Envelope falls by a fixed step each cycle
			if (mag > s_q.peak + accel_tol) begin
				s_d.viol = 1'b1;
			end
			s_d.peak = (s_q.peak > ramp_step) ? s_q.peak - ramp_step : '0;
		end else begin
			// Track the lowest speed seen; any rise beyond tolerance is bad
			if (mag > s_q.peak + accel_tol) begin
				s_d.viol = 1'b1;
			end
			if (mag < s_q.peak) begin
				s_d.peak = mag;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign violation = s_q.viol;

endmodule // speed_monitor

// ### hdl/drive_standstill_speed_safety.sv
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// How it works
// - Standstill supervision arms only after its configured delay fully elapses.
// - Position at activation is latched as reference until deselection.
// - Deselecting standstill supervision cancels the delay and frees motion at once.
// - Position outside tolerance window while active starts brake-then-torque-off stop.
// - Brake-then-standstill stop forces closed-loop speed control.
// - Stationary at brake-then-standstill selection: wait delay, then standstill supervision.
// - Moving: fast-stop ramp, configured braking monitor, standstill after delay.
// - Braking monitor violation removes torque.
// - External variant runs no braking monitor; controller stops the drive.
// - Limited speed selected from fail-safe input or fieldbus channel.
// - Excess speed may be reduced within a defined time before enforcement.
// - Velocity magnitude, ignoring sign, is compared with the limit.
// - Setpoint limit is output; optional ramp clamp sits below the limit.
// - Brake-ramp monitor on limited-speed entry only without encoder.
// - Unselected configuration: always active while the fixed-mode control bit is set; level 0 limit output, also compared unless limited speed was already on.
// - Deselection stops both setpoint limiting and velocity monitoring.
// - Four selectable speed limit levels while active.
// - Raising the level compares against the higher limit immediately.
// - Brake-then-torque-off stop removes torque before its delay when speed falls low enough.
module drive_standstill_speed_safety (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic                    sel_sos_pin,
	input  wire logic                    sel_ss2_pin,
	input  wire logic                    sel_sls_pin,
	input  wire logic [1:0]              sls_level_pin,
	input  wire logic                    encoder_present,
	input  wire logic                    torque_ctrl_mode,
	input  wire safety_pkg::feedback_s   feedback,
	output safety_pkg::drive_cmd_s       cmd,
	output logic      [31:0]             speed_limit_out,
	output logic      [31:0]             ramp_max_speed
);

	typedef struct packed {
		logic [safety_pkg::CTRL_W-1:0] ctrl;
		logic [31:0]                   sos_dly;
		logic [31:0]                   ss2_dly;
		logic [31:0]                   sls_dly;
		logic [31:0]                   ss1_dly;
		logic [31:0]                   tol;
		logic [31:0]                   still;
		logic [31:0]                   accel;
		logic [31:0]                   ramp;
		logic [3:0][31:0]              lim;
		logic [31:0]                   margin;
		safety_pkg::stop_e             st;
		logic [31:0]                   ref_pos;
		logic [1:0]                    lvl;
		logic                          sls_on;
		logic                          sls_enf;
		logic                          ss2_mon;
		logic                          sls_mon;
		logic [2:0]                    pin1;
		logic [2:0]                    pin2;
		logic [1:0]                    lpin1;
		logic [1:0]                    lpin2;
		logic [1:0]                    sel_q;
		safety_pkg::drive_cmd_s        cmd;
		logic [31:0]                   lim_out;
		logic [31:0]                   ramp_out;
		logic [31:0]                   rdata;
		logic                          ready;
		logic                          err;
	} st_s;

	st_s          s_q;
	st_s          s_d;
	logic         sos_sel;
	logic         ss2_sel;
	logic         sls_sel;
	logic [1:0]   lvl_sel;
	logic         fixed_mode;
	logic [31:0]  vmag;
	logic [31:0]  pdiff;
	logic         still_now;
	logic         sos_start;
	logic         ss2_start;
	logic         ss1_start;
	logic         sls_start;
	logic         sos_done;
	logic         ss2_done;
	logic         ss1_done;
	logic         sls_done;
	logic         sls_run;
	logic         ss2_viol;
	logic         sls_viol;
	logic         sos_clear;
	logic         ss2_clear;
	logic         sls_clear;
	logic         wr;
	logic         rd;
	logic [31:0]  active_lim;

	// Magnitude helper shared by speed and position checks

	function automatic logic [31:0] absval(input logic [31:0] v);
		absval = v[31] ? 32'(-v) : v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Selection sources and measurement

	assign sos_sel    = s_q.pin2[0] | s_q.ctrl[safety_pkg::CTRL_SOS_SEL];
	assign ss2_sel    = s_q.pin2[1] | s_q.ctrl[safety_pkg::CTRL_SS2_SEL];
	assign fixed_mode = s_q.ctrl[safety_pkg::CTRL_SLS_FIXED];
	assign sls_sel    = fixed_mode | s_q.pin2[2]
		| s_q.ctrl[safety_pkg::CTRL_SLS_SEL];
	assign lvl_sel    = fixed_mode ? 2'h0
		: (s_q.lpin2 | s_q.ctrl[safety_pkg::CTRL_LVL_LO +: 2]);

	assign vmag       = absval(feedback.vel);
	assign pdiff      = absval(32'(feedback.pos - s_q.ref_pos));
	assign still_now  = vmag <= s_q.still;
	assign active_lim = s_q.lim[s_q.lvl];

	assign wr = psel & penable & pwrite & ~s_q.ready;
	assign rd = psel & penable & ~pwrite & ~s_q.ready;

	////////////////////////////////////////////////////////////////////////
	// Timers and braking monitors

	assign sos_start = (s_q.st == safety_pkg::ST_RUN) & sos_sel & ~ss2_sel;
	assign ss2_start = (s_q.st == safety_pkg::ST_RUN) & ss2_sel;
	assign ss1_start = s_d.st == safety_pkg::ST_SS1_BRAKE
		&& s_q.st != safety_pkg::ST_SS1_BRAKE;
	assign sls_start = sls_sel & ~s_q.sls_on;
	assign sos_clear = ~sos_sel & (s_q.st == safety_pkg::ST_SOS_WAIT);
	assign ss2_clear = ~ss2_sel & (s_q.st == safety_pkg::ST_SS2_BRAKE);
	assign sls_clear = ~sls_sel;

	delay_timer #(.W(32)) u_sos_tmr (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (sos_start),
		.clear   (sos_clear),
		.load    (s_q.sos_dly),
		.running (),
		.done    (sos_done)
	);

	delay_timer #(.W(32)) u_ss2_tmr (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (ss2_start),
		.clear   (ss2_clear),
		.load    (s_q.ss2_dly),
		.running (),
		.done    (ss2_done)
	);

	delay_timer #(.W(32)) u_ss1_tmr (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (ss1_start),
		.clear   (1'b0),
		.load    (s_q.ss1_dly),
		.running (),
		.done    (ss1_done)
	);

	delay_timer #(.W(32)) u_sls_tmr (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (sls_start),
		.clear   (sls_clear),
		.load    (s_q.sls_dly),
		.running (sls_run),
		.done    (sls_done)
	);

	speed_monitor #(.W(32)) u_ss2_mon (
		.pclk      (pclk),
		.presetn   (presetn),
		.enable    (s_q.ss2_mon),
		.use_ramp  (s_q.ctrl[safety_pkg::CTRL_MON_SEL]),
		.vel       (feedback.vel),
		.accel_tol (s_q.accel),
		.ramp_step (s_q.ramp),
		.violation (ss2_viol)
	);

	speed_monitor #(.W(32)) u_sls_mon (
		.pclk      (pclk),
		.presetn   (presetn),
		.enable    (s_q.sls_mon),
		.use_ramp  (1'b1),
		.vel       (feedback.vel),
		.accel_tol (s_q.accel),
		.ramp_step (s_q.ramp),
		.violation (sls_viol)
	);

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		s_d       = s_q;
		s_d.pin1  = {sel_sls_pin, sel_ss2_pin, sel_sos_pin};
		s_d.pin2  = s_q.pin1;
		s_d.lpin1 = sls_level_pin;
		s_d.lpin2 = s_q.lpin1;
		s_d.ready = 1'b0;
		s_d.err   = 1'b0;

		// APB slave, one wait state
		if (wr | rd) begin
			s_d.ready = 1'b1;
		end
		if (wr) begin
			case (paddr)
				safety_pkg::ADDR_CTRL: begin
					s_d.ctrl = pwdata[safety_pkg::CTRL_W-1:0];
				end
				safety_pkg::ADDR_SOS_DLY: s_d.sos_dly = pwdata;
				safety_pkg::ADDR_SS2_DLY: s_d.ss2_dly = pwdata;
				safety_pkg::ADDR_SLS_DLY: s_d.sls_dly = pwdata;
				safety_pkg::ADDR_SS1_DLY: s_d.ss1_dly = pwdata;
				safety_pkg::ADDR_TOL:     s_d.tol     = pwdata;
				safety_pkg::ADDR_STILL:   s_d.still   = pwdata;
				safety_pkg::ADDR_ACCEL:   s_d.accel   = pwdata;
				safety_pkg::ADDR_RAMP:    s_d.ramp    = pwdata;
				safety_pkg::ADDR_LIM0:    s_d.lim[0]  = pwdata;
				safety_pkg::ADDR_LIM1:    s_d.lim[1]  = pwdata;
				safety_pkg::ADDR_LIM2:    s_d.lim[2]  = pwdata;
				safety_pkg::ADDR_LIM3:    s_d.lim[3]  = pwdata;
				safety_pkg::ADDR_MARGIN:  s_d.margin  = pwdata;
				safety_pkg::ADDR_STATUS:  s_d.err     = 1'b1;
				safety_pkg::ADDR_REFPOS:  s_d.err     = 1'b1;
				default:                  s_d.err     = 1'b1;
			endcase
		end
		if (rd) begin
			case (paddr)
				safety_pkg::ADDR_CTRL:    s_d.rdata = 32'(s_q.ctrl);
				safety_pkg::ADDR_SOS_DLY: s_d.rdata = s_q.sos_dly;
				safety_pkg::ADDR_SS2_DLY: s_d.rdata = s_q.ss2_dly;
				safety_pkg::ADDR_SLS_DLY: s_d.rdata = s_q.sls_dly;
				safety_pkg::ADDR_SS1_DLY: s_d.rdata = s_q.ss1_dly;
				safety_pkg::ADDR_TOL:     s_d.rdata = s_q.tol;
				safety_pkg::ADDR_STILL:   s_d.rdata = s_q.still;
				safety_pkg::ADDR_ACCEL:   s_d.rdata = s_q.accel;
				safety_pkg::ADDR_RAMP:    s_d.rdata = s_q.ramp;
				safety_pkg::ADDR_LIM0:    s_d.rdata = s_q.lim[0];
				safety_pkg::ADDR_LIM1:    s_d.rdata = s_q.lim[1];
				safety_pkg::ADDR_LIM2:    s_d.rdata = s_q.lim[2];
				safety_pkg::ADDR_LIM3:    s_d.rdata = s_q.lim[3];
				safety_pkg::ADDR_MARGIN:  s_d.rdata = s_q.margin;
				safety_pkg::ADDR_STATUS: begin
					s_d.rdata = {19'h0_0000, s_q.lvl, 3'(s_q.st),
						s_q.sls_enf, s_q.cmd};
				end
				safety_pkg::ADDR_REFPOS:  s_d.rdata = s_q.ref_pos;
				default: begin
					s_d.rdata = 32'h0000_0000;
					s_d.err   = 1'b1;
				end
			endcase
		end

		// Stop sequence
		case (s_q.st)
			safety_pkg::ST_RUN: begin
				if (ss2_sel) begin
					s_d.st      = safety_pkg::ST_SS2_BRAKE;
					s_d.ss2_mon = ~s_q.ctrl[safety_pkg::CTRL_SS2_EXT]
						& ~still_now;
				end else if (sos_sel) begin
					s_d.st = safety_pkg::ST_SOS_WAIT;
				end
			end
			safety_pkg::ST_SOS_WAIT: begin
				if (!sos_sel) begin
					s_d.st = safety_pkg::ST_RUN;
				end else if (sos_done) begin
					s_d.st      = safety_pkg::ST_SOS_ACT;
					s_d.ref_pos = feedback.pos;
				end
			end
			safety_pkg::ST_SS2_BRAKE: begin
				if (!ss2_sel) begin
					s_d.st      = safety_pkg::ST_RUN;
					s_d.ss2_mon = 1'b0;
				end else if (ss2_viol) begin
					s_d.st      = safety_pkg::ST_TORQUE_OFF;
					s_d.ss2_mon = 1'b0;
				end else if (ss2_done) begin
					s_d.st      = safety_pkg::ST_SOS_ACT;
					s_d.ss2_mon = 1'b0;
					s_d.ref_pos = feedback.pos;
				end
			end
			safety_pkg::ST_SOS_ACT: begin
				if (!sos_sel && !ss2_sel) begin
					s_d.st = safety_pkg::ST_RUN;
				end else if (pdiff > s_q.tol) begin
					s_d.st = safety_pkg::ST_SS1_BRAKE;
				end
			end
			safety_pkg::ST_SS1_BRAKE: begin
				if (still_now || ss1_done) begin
					s_d.st = safety_pkg::ST_TORQUE_OFF;
				end
			end
			safety_pkg::ST_TORQUE_OFF: begin
				// Latched until acknowledged with neither standstill nor braking stop selected
				if (s_q.ctrl[safety_pkg::CTRL_ACK] && !sos_sel
					&& !ss2_sel) begin
					s_d.st = safety_pkg::ST_RUN;
				end
			end
			default: s_d.st = safety_pkg::ST_TORQUE_OFF;
		endcase

		// Limited speed supervision
		s_d.sls_on = sls_sel;
		if (!sls_sel) begin
			s_d.sls_enf = 1'b0;
			s_d.sls_mon = 1'b0;
		end else begin
			if (!fixed_mode || !s_q.sls_on) begin
				s_d.lvl = lvl_sel;
			end
			if (sls_done || (sls_start && s_q.sls_dly == '0)) begin
				s_d.sls_enf = 1'b1;
			end
			s_d.sls_mon = sls_run & ~encoder_present
				& s_q.ctrl[safety_pkg::CTRL_SLS_SBR];
		end
		// new limit compared at once via lvl
		if (s_q.sls_enf && vmag > active_lim
			&& s_q.st != safety_pkg::ST_TORQUE_OFF) begin
			s_d.st = safety_pkg::ST_SS1_BRAKE;
		end
		if (sls_viol && s_q.st != safety_pkg::ST_TORQUE_OFF) begin
			s_d.st = safety_pkg::ST_SS1_BRAKE;
		end

		s_d.lim_out  = sls_sel ? s_q.lim[lvl_sel] : 32'hFFFF_FFFF;
		s_d.ramp_out = sls_sel
			? ((s_q.lim[lvl_sel] > s_q.margin)
				? s_q.lim[lvl_sel] - s_q.margin : 32'h0000_0000)
			: 32'hFFFF_FFFF;

		s_d.cmd.torque_off   = s_d.st == safety_pkg::ST_TORQUE_OFF;
		s_d.cmd.fast_stop    = s_d.st == safety_pkg::ST_SS2_BRAKE
			&& !s_q.ctrl[safety_pkg::CTRL_SS2_EXT]
			|| s_d.st == safety_pkg::ST_SS1_BRAKE;
		s_d.cmd.speed_ctrl   = ss2_sel | ~torque_ctrl_mode;
		s_d.cmd.sos_active   = s_d.st == safety_pkg::ST_SOS_ACT;
		s_d.cmd.sos_selected = sos_sel | ss2_sel;
		s_d.cmd.sls_active   = s_d.sls_enf;
		s_d.cmd.fault        = s_d.st == safety_pkg::ST_TORQUE_OFF
			|| s_d.st == safety_pkg::ST_SS1_BRAKE;
		s_d.sel_q            = {ss2_sel, sos_sel};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q          <= '0;
			s_q.sos_dly  <= safety_pkg::DLY_RST;
			s_q.ss2_dly  <= safety_pkg::DLY_RST;
			s_q.sls_dly  <= safety_pkg::DLY_RST;
			s_q.ss1_dly  <= safety_pkg::DLY_RST;
			s_q.tol      <= safety_pkg::TOL_RST;
			s_q.still    <= safety_pkg::STILL_RST;
			s_q.accel    <= safety_pkg::ACCEL_RST;
			s_q.ramp     <= safety_pkg::RAMP_RST;
			s_q.lim      <= {4{safety_pkg::LIM_RST}};
			s_q.margin   <= safety_pkg::MARGIN_RST;
			s_q.st       <= safety_pkg::ST_RUN;
			s_q.lim_out  <= 32'hFFFF_FFFF;
			s_q.ramp_out <= 32'hFFFF_FFFF;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata          = s_q.rdata;
	assign pready          = s_q.ready;
	assign pslverr         = s_q.err;
	assign cmd             = s_q.cmd;
	assign speed_limit_out = s_q.lim_out;
	assign ramp_max_speed  = s_q.ramp_out;

endmodule // drive_standstill_speed_safety

// ### tb/drive_safety_monitor.sv
`timescale 1ns/1ps
module drive_safety_monitor (
	input wire logic                   pclk,
	input wire logic                   presetn,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [7:0]             paddr,
	input wire logic [31:0]            pwdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	input wire logic                   sel_sos_pin,
	input wire logic                   sel_ss2_pin,
	input wire logic                   torque_ctrl_mode,
	input wire safety_pkg::drive_cmd_s cmd,
	input wire logic [31:0]            speed_limit_out,
	input wire logic [31:0]            ramp_max_speed
);
	logic       wr_ctrl;
	logic [2:0] sw_sel_q;
	logic [2:0] sw_sel_d;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	assign wr_ctrl = psel && penable && pwrite
		&& paddr == safety_pkg::ADDR_CTRL;
	////////////////////////////////////////////////////////////
	// Shadow of the bus selects, so pin-only checks stay honest
	always_comb begin
		sw_sel_d = sw_sel_q;
		if (wr_ctrl && pready && !pslverr) begin
			sw_sel_d = pwdata[2:0];
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_sel_q <= 3'h0;
		end else begin
			sw_sel_q <= sw_sel_d;
		end
	end
	////////////////////////////////////////////////////////////
	chk_apb_wait_state: assert property ($rose(penable) && psel
		|-> !pready ##1 pready) else $error("bad wait state");
	chk_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_sos_release: assert property (
		$fell(sel_sos_pin) && !sel_ss2_pin && sw_sel_q[1:0] == 2'h0
		|-> ##[1:4] !cmd.sos_active) else $error("standstill held");
	chk_torque_latch: assert property (
		cmd.torque_off && !wr_ctrl && !$past(wr_ctrl)
		&& !$past(wr_ctrl, 2) |=> cmd.torque_off)
		else $error("torque off dropped");
	chk_brake_first: assert property (
		$rose(cmd.torque_off) |-> $past(cmd.fast_stop))
		else $error("torque off without braking");
	chk_limit_off: assert property (
		$fell(cmd.sls_active) |-> ##[0:2]
		speed_limit_out == 32'hFFFF_FFFF
		&& ramp_max_speed == 32'hFFFF_FFFF)
		else $error("limit kept after deselect");
	chk_ramp_below: assert property (
		speed_limit_out != 32'hFFFF_FFFF |-> ramp_max_speed
		< speed_limit_out || ramp_max_speed == 32'h0)
		else $error("ramp clamp not below limit");
	chk_ss2_entry: assert property (
		$rose(sel_ss2_pin) && !sw_sel_q[2] && !cmd.torque_off
		|-> ##[1:4] cmd.fast_stop
		&& (cmd.speed_ctrl || !torque_ctrl_mode))
		else $error("braking stop not entered");
endmodule // drive_safety_monitor

bind drive_standstill_speed_safety drive_safety_monitor u_monitor (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pready, .pslverr, .sel_sos_pin, .sel_ss2_pin, .torque_ctrl_mode,
	.cmd, .speed_limit_out, .ramp_max_speed
);

// ### tb/motion_controller_model.sv
`timescale 1ns/1ps
module motion_controller_model (
	input wire logic                   pclk,
	input wire logic                   presetn,
	input wire safety_pkg::drive_cmd_s cmd,
	input wire logic [31:0]            set_vel,
	input wire logic                   accel,
	input wire logic                   nudge,
	input wire logic                   halt,
	output safety_pkg::feedback_s      feedback
);
	safety_pkg::feedback_s fb_q;
	safety_pkg::feedback_s fb_d;
	assign feedback = fb_q;
	always_comb begin
		fb_d = fb_q;
		fb_d.pos = fb_q.pos + fb_q.vel + (nudge ? 32'h0000_0040 : 32'h0);
		// overspeed on demand, stop when asked
		if (accel) begin
			fb_d.vel = fb_q.vel + 32'h0000_0040;
		end else if (cmd.sos_selected || cmd.fast_stop || halt
			|| cmd.torque_off) begin
			fb_d.vel = 32'($signed(fb_q.vel) >>> 1);
		end else begin
			fb_d.vel = set_vel;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fb_q <= '{pos: 32'h0000_1000, vel: 32'h0};
		end else begin
			fb_q <= fb_d;
		end
	end
endmodule // motion_controller_model

// ### tb/test_drive_standstill_speed_safety.sv
`timescale 1ns/1ps
module test_drive_standstill_speed_safety;
	localparam int D = 64;
	logic                   pclk;
	logic                   presetn;
	logic                   psel, penable, pwrite;
	logic [7:0]             paddr;
	logic [31:0]            pwdata, prdata, set_vel, lim;
	logic                   pready, pslverr, accel, nudge, halt;
	logic                   sel_sos_pin, sel_ss2_pin, sel_sls_pin;
	logic [1:0]             sls_level_pin;
	logic                   encoder_present, torque_ctrl_mode;
	safety_pkg::feedback_s  feedback;
	safety_pkg::drive_cmd_s cmd;
	logic [6:0]             cv;
	logic [31:0]            speed_limit_out, ramp_max_speed;
	int                     fail_count, checked;
	assign cv = cmd;
	drive_standstill_speed_safety DUT (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.sel_sos_pin, .sel_ss2_pin, .sel_sls_pin, .sls_level_pin,
		.encoder_present, .torque_ctrl_mode, .feedback, .cmd,
		.speed_limit_out, .ramp_max_speed);
	motion_controller_model partner (.pclk, .presetn, .cmd, .set_vel,
		.accel, .nudge, .halt, .feedback);
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e,
		input string m);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic err);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		chk({31'h0, pslverr}, {31'h0, err}, "bus error flag");
		if (!w && !err) chk(prdata, d, "read data");
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wait_cmd(input int b, input logic v, input int lim_c);
		int n;
		n = 0;
		while (cv[b] !== v && n < lim_c) begin
			@(posedge pclk);
			n++;
		end
		chk({31'h0, cv[b]}, {31'h0, v}, "command bit");
	endtask
	task automatic hold_cmd(input int b, input logic v, input int c);
		repeat (c) begin
			@(posedge pclk);
			chk({31'h0, cv[b]}, {31'h0, v}, "command bit held");
		end
	endtask
	task automatic ack();
		repeat (4) @(posedge pclk);
		acc(1'b1, safety_pkg::ADDR_CTRL, 32'h0000_0200, 1'b0);
		acc(1'b1, safety_pkg::ADDR_CTRL, 32'h0, 1'b0);
		wait_cmd(6, 1'b0, 4);
	endtask
	task automatic print_verdict();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		$display("unexpected at %0t: watchdog", $time);
		print_verdict();
	end
	////////////////////////////////////////////////////////////
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata, set_vel} = '0;
		{sel_sos_pin, sel_ss2_pin, sel_sls_pin, sls_level_pin} = '0;
		{encoder_present, torque_ctrl_mode, accel, nudge, halt} = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		acc(1'b0, safety_pkg::ADDR_SOS_DLY, safety_pkg::DLY_RST, 1'b0);
		acc(1'b0, safety_pkg::ADDR_TOL, safety_pkg::TOL_RST, 1'b0);
		acc(1'b0, 8'h40, 32'h0, 1'b1);
		acc(1'b1, safety_pkg::ADDR_STATUS, 32'h0, 1'b1);
		chk(speed_limit_out, 32'hFFFF_FFFF, "limit at reset"); // off
		for (int i = 0; i < 4; i++) begin
			acc(1'b1, safety_pkg::ADDR_SOS_DLY + 8'(4 * i), 32'(D), 1'b0);
			acc(1'b1, safety_pkg::ADDR_LIM0 + 8'(4 * i),
				safety_pkg::LIM_RST + 32'(64 * i), 1'b0);
		end
		set_vel <= 32'h0000_0003;
		sel_sos_pin <= 1'b1;
		wait_cmd(2, 1'b1, 4); // selected flag
		hold_cmd(3, 1'b0, D - 8); // no early arming
		wait_cmd(3, 1'b1, 16); // armed
		acc(1'b0, safety_pkg::ADDR_REFPOS, feedback.pos, 1'b0); // ref
		sel_sos_pin <= 1'b0;
		wait_cmd(3, 1'b0, 4); // released
		set_vel <= 32'h0;
		sel_sos_pin <= 1'b1;
		wait_cmd(3, 1'b1, D + 16);
		nudge <= 1'b1;
		@(posedge pclk);
		nudge <= 1'b0;
		wait_cmd(5, 1'b1, 4); // braking
		wait_cmd(6, 1'b1, D + 8); // torque off
		sel_sos_pin <= 1'b0;
		ack();
		torque_ctrl_mode <= 1'b1;
		set_vel <= 32'h0000_0005;
		sel_ss2_pin <= 1'b1;
		wait_cmd(5, 1'b1, 4); // ramp
		chk({31'h0, cv[4]}, 32'h1, "speed control"); // mode
		wait_cmd(3, 1'b1, D + 16); // standstill
		sel_ss2_pin <= 1'b0;
		wait_cmd(3, 1'b0, 4);
		sel_ss2_pin <= 1'b1;
		wait_cmd(5, 1'b1, 4);
		accel <= 1'b1;
		wait_cmd(6, 1'b1, 16); // acceleration trip
		accel <= 1'b0;
		sel_ss2_pin <= 1'b0;
		ack();
		halt <= 1'b1;
		acc(1'b1, safety_pkg::ADDR_CTRL, 32'h0000_0006, 1'b0);
		hold_cmd(5, 1'b0, 8); // no ramp
		wait_cmd(3, 1'b1, D + 16); // standstill
		acc(1'b1, safety_pkg::ADDR_CTRL, 32'h0, 1'b0);
		halt <= 1'b0;
		wait_cmd(3, 1'b0, 4);
		set_vel <= 32'h0;
		for (int i = 0; i < 4; i++) begin
			acc(1'b1, safety_pkg::ADDR_CTRL, 32'(8 | (i << 4)), 1'b0);
			wait_cmd(1, 1'b1, D + 8);
			repeat (2) @(posedge pclk);
			lim = safety_pkg::LIM_RST + 32'(64 * i);
			chk(speed_limit_out, lim, "limit level"); // level
			chk(ramp_max_speed, lim - safety_pkg::MARGIN_RST, "clamp");
		end
		acc(1'b1, safety_pkg::ADDR_CTRL, 32'h0, 1'b0);
		wait_cmd(1, 1'b0, 4); // deselected
		repeat (2) @(posedge pclk);
		chk(ramp_max_speed, 32'hFFFF_FFFF, "clamp off"); // clamp
		acc(1'b1, safety_pkg::ADDR_CTRL, 32'h0000_0130, 1'b0);
		repeat (2) @(posedge pclk);
		chk(speed_limit_out, safety_pkg::LIM_RST, "fixed limit");
		acc(1'b1, safety_pkg::ADDR_CTRL, 32'h0, 1'b0);
		repeat (2) @(posedge pclk);
		chk(speed_limit_out, 32'hFFFF_FFFF, "fixed off");
		set_vel <= 32'hFFFF_FEB0;
		sel_sls_pin <= 1'b1;
		hold_cmd(5, 1'b0, D - 8); // grace
		wait_cmd(5, 1'b1, 24); // magnitude trip
		wait_cmd(6, 1'b1, D + 8); // torque off
		sel_sls_pin <= 1'b0;
		ack();
		print_verdict();
	end
endmodule // test_drive_standstill_speed_safety
